/* File: hw/rhs_pkg.sv */
// Package: offsets, fields, reset values and states of the root hub status block
package rhs_pkg;

  // Command codes; read and write codes select the same register
  localparam logic [7:0] READ_CODE        = 8'h14;
  localparam logic [7:0] WRITE_CODE       = 8'h94;

  // Avalon word addresses (byte address / 4)
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h21;
  localparam logic [7:0] ADDR_CTRL        = 8'h22;

  // Field positions in root_hub_status
  localparam int BIT_LOCAL_POWER_OFF     = 0;
  localparam int BIT_OVERCURRENT         = 1;
  localparam int BIT_WAKEUP_ENABLE       = 15;
  localparam int BIT_POWER_ON            = 16;
  localparam int BIT_OVERCURRENT_CHANGE  = 17;
  localparam int BIT_CLEAR_WAKEUP        = 31;

  // Control register fields
  localparam int BIT_CTRL_PER_PORT_POWER = 0;
  localparam int BIT_CTRL_PER_PORT_OC    = 1;

  // Interrupt status bit positions
  localparam int IRQ_OC_CHANGE           = 0;
  localparam int IRQ_RESUME              = 1;
  localparam int IRQ_WIDTH               = 2;

  // Reset values
  localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;

  // Controller USB state
  typedef enum logic [2:0] {
    ST_OPERATIONAL = 3'b001,
    ST_SUSPEND     = 3'b010,
    ST_RESUME      = 3'b100
  } rhs_state_type;

endpackage

/* File: hw/rhs_port_power.sv */
// Per-port power state, driven by global or per-port power commands
`timescale 1ns/1ps
module rhs_port_power #(
  parameter int NUM_PORTS = 2
) (
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RESETN_IN,
  input  wire logic                 PER_PORT_MODE_IN,
  input  wire logic [NUM_PORTS:1]   PORT_MASK_IN,
  input  wire logic                 GLOBAL_ON_IN,
  input  wire logic                 GLOBAL_OFF_IN,
  input  wire logic [NUM_PORTS:1]   PORT_SET_IN,
  input  wire logic [NUM_PORTS:1]   PORT_CLR_IN,
  output logic      [NUM_PORTS:1]   POWER_OUT
);

  logic [NUM_PORTS:1] affected;
  logic [NUM_PORTS:1] power_q;

  // Masked ports ignore global commands in per-port mode
  assign affected = PER_PORT_MODE_IN ? ~PORT_MASK_IN : '1;

  // On wins over off if both are written in one word
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      power_q <= '0;
    end else begin
      power_q <= (power_q & ~PORT_CLR_IN & ~({NUM_PORTS{GLOBAL_OFF_IN}}
                 & affected))
                 | PORT_SET_IN
                 | ({NUM_PORTS{GLOBAL_ON_IN}} & affected);
    end
  end

  assign POWER_OUT = power_q;

endmodule

/* File: hw/rhs_wakeup.sv */
// Suspend/resume tracker: connect change wakes the controller when enabled
`timescale 1ns/1ps
module rhs_wakeup (
  input  wire logic REF_CLK_IN,
  input  wire logic RESETN_IN,
  input  wire logic SUSPEND_REQ_IN,
  input  wire logic RESUME_DONE_IN,
  input  wire logic WAKEUP_ENABLE_IN,
  input  wire logic CONNECT_CHANGE_IN,
  output logic      RESUME_EVENT_OUT,
  output logic [2:0] STATE_OUT
);

  rhs_pkg::rhs_state_type state_q;
  logic                   wake;

  // Connect change counts only while suspended and enabled
  assign wake = WAKEUP_ENABLE_IN && CONNECT_CHANGE_IN
                && (state_q == rhs_pkg::ST_SUSPEND);

  // State update
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= rhs_pkg::ST_OPERATIONAL;
    end else begin
      unique case (state_q)
        rhs_pkg::ST_OPERATIONAL: begin
          if (SUSPEND_REQ_IN) begin
            state_q <= rhs_pkg::ST_SUSPEND;
          end
        end
        rhs_pkg::ST_SUSPEND: begin
          if (wake) begin
            state_q <= rhs_pkg::ST_RESUME;
          end
        end
        rhs_pkg::ST_RESUME: begin
          if (RESUME_DONE_IN) begin
            state_q <= rhs_pkg::ST_OPERATIONAL;
          end
        end
        default: begin
          state_q <= rhs_pkg::ST_OPERATIONAL;
        end
      endcase
    end
  end

  // One-cycle pulse raised when resume is detected
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RESUME_EVENT_OUT <= 1'b0;
    end else begin
      RESUME_EVENT_OUT <= wake;
    end
  end

  assign STATE_OUT = state_q;

endmodule

/* File: hw/rhs_top.sv */
// Root hub status register with Avalon-MM slave and interrupt logic
//
// Behaviour
// - codes 14h read, 94h write, one register
// - status low half, change bits high half
// - bit31 clears wake enable, bit15 sets
// - overcurrent change set on indicator change
// - overcurrent change cleared by writing one
// - bits 16 and 0 always read zero
// - global mode: bit16 write powers all ports
// - per-port mode: bit16 powers unmasked ports
// - global mode: bit0 write powers off all
// - per-port mode: bit0 unpowers unmasked ports
// - enabled connect change resumes from suspend
// - bit1 reads overcurrent in global reporting
// - per-port overcurrent makes bit1 read zero
// - per-port mode: masked ports ignore global power commands
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rhs_top #(
  parameter int NUM_PORTS = 2
) (
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RESETN_IN,
  input  wire logic [7:0]           AVS_ADDRESS_IN,
  input  wire logic                 AVS_READ_IN,
  input  wire logic                 AVS_WRITE_IN,
  input  wire logic [31:0]          AVS_WRITEDATA_IN,
  input  wire logic [3:0]           AVS_BYTEENABLE_IN,
  output logic      [31:0]          AVS_READDATA_OUT,
  output logic                      AVS_WAITREQUEST_OUT,
  output logic      [1:0]           AVS_RESPONSE_OUT,
  input  wire logic                 OVERCURRENT_IN,
  input  wire logic [NUM_PORTS:1]   PORT_POWER_MASK_IN,
  input  wire logic [NUM_PORTS:1]   PORT_POWER_SET_IN,
  input  wire logic [NUM_PORTS:1]   PORT_POWER_CLR_IN,
  input  wire logic                 CONNECT_CHANGE_IN,
  input  wire logic                 SUSPEND_REQ_IN,
  input  wire logic                 RESUME_DONE_IN,
  output logic      [NUM_PORTS:1]   PORT_POWER_OUT,
  output logic                      RESUME_DETECTED_OUT,
  output logic      [2:0]           USB_STATE_OUT,
  output logic                      IRQ_OUT
);

  logic                 remote_wakeup_enable_q;
  logic                 overcurrent_change_flag_q;
  logic                 oc_seen_q;
  logic                 global_overcurrent_indicator;
  logic [1:0]           ctrl_q;
  logic [rhs_pkg::IRQ_WIDTH-1:0] irq_stat_q;
  logic [rhs_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic                 ack_q;
  logic [31:0]          rdata_d;
  logic [1:0]           resp_d;
  logic                 wr_fire;
  logic                 hit_status;
  logic                 hit_irq_stat;
  logic                 hit_irq_mask;
  logic                 hit_ctrl;
  logic                 mapped;
  logic [31:0]          wmask;
  logic [31:0]          wdata;
  logic                 cmd_power_on;
  logic                 cmd_power_off;
  logic                 cmd_wake_set;
  logic                 cmd_wake_clr;
  logic                 cmd_occ_clr;
  logic                 oc_changed;
  logic                 resume_pulse;

  // Expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Address decode; status read and write codes share one word
  assign hit_status   = (AVS_ADDRESS_IN == rhs_pkg::READ_CODE)
                        || (AVS_ADDRESS_IN == rhs_pkg::WRITE_CODE);
  assign hit_irq_stat = AVS_ADDRESS_IN == rhs_pkg::ADDR_IRQ_STAT;
  assign hit_irq_mask = AVS_ADDRESS_IN == rhs_pkg::ADDR_IRQ_MASK;
  assign hit_ctrl     = AVS_ADDRESS_IN == rhs_pkg::ADDR_CTRL;
  assign mapped       = hit_status | hit_irq_stat | hit_irq_mask | hit_ctrl;

  // One wait cycle per access: waitrequest drops the cycle after request
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
  assign wr_fire = AVS_WRITE_IN & ack_q;
  assign wmask   = lane_mask(AVS_BYTEENABLE_IN);
  assign wdata   = AVS_WRITEDATA_IN & wmask;

  // Ack toggles so back-to-back requests each see one wait cycle
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
    end
  end

  // Write commands are pulses; reserved bits written by software are dropped
  assign cmd_power_on  = wr_fire & hit_status
                         & wdata[rhs_pkg::BIT_POWER_ON];
  assign cmd_power_off = wr_fire & hit_status
                         & wdata[rhs_pkg::BIT_LOCAL_POWER_OFF];
  assign cmd_wake_set  = wr_fire & hit_status
                         & wdata[rhs_pkg::BIT_WAKEUP_ENABLE];
  assign cmd_wake_clr  = wr_fire & hit_status
                         & wdata[rhs_pkg::BIT_CLEAR_WAKEUP];
  assign cmd_occ_clr   = wr_fire & hit_status
                         & wdata[rhs_pkg::BIT_OVERCURRENT_CHANGE];

  // Remote wake-up enable; clear wins if both command bits are one
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      remote_wakeup_enable_q <= 1'b0;
    end else if (cmd_wake_clr) begin
      remote_wakeup_enable_q <= 1'b0;
    end else if (cmd_wake_set) begin
      remote_wakeup_enable_q <= 1'b1;
    end
  end

  // Global indicator is forced low when overcurrent is reported per port
  assign global_overcurrent_indicator =
    OVERCURRENT_IN & ~ctrl_q[rhs_pkg::BIT_CTRL_PER_PORT_OC];

  // Registered copy of the indicator for change detection
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      oc_seen_q <= 1'b0;
    end else begin
      oc_seen_q <= global_overcurrent_indicator;
    end
  end

  assign oc_changed = oc_seen_q ^ global_overcurrent_indicator;

  // Change flag: hardware set wins over a simultaneous software clear
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      overcurrent_change_flag_q <= 1'b0;
    end else if (oc_changed) begin
      overcurrent_change_flag_q <= 1'b1;
    end else if (cmd_occ_clr) begin
      overcurrent_change_flag_q <= 1'b0;
    end
  end

  // Control register: power switching mode and overcurrent reporting mode
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_q <= rhs_pkg::CTRL_RESET;
    end else if (wr_fire && hit_ctrl && AVS_BYTEENABLE_IN[0]) begin
      ctrl_q <= AVS_WRITEDATA_IN[1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_mask_q <= '0;
    end else if (wr_fire && hit_irq_mask) begin
      irq_mask_q <= wdata[rhs_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Sticky interrupt status, write one to clear; new events win
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q
                     & ~({rhs_pkg::IRQ_WIDTH{wr_fire & hit_irq_stat}}
                         & wdata[rhs_pkg::IRQ_WIDTH-1:0]))
                    | {resume_pulse, oc_changed};
    end
  end

  assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

  // Port power state
  rhs_port_power #(
    .NUM_PORTS (NUM_PORTS)
  ) u_power (
    .REF_CLK_IN       (REF_CLK_IN),
    .RESETN_IN        (RESETN_IN),
    .PER_PORT_MODE_IN (ctrl_q[rhs_pkg::BIT_CTRL_PER_PORT_POWER]),
    .PORT_MASK_IN     (PORT_POWER_MASK_IN),
    .GLOBAL_ON_IN     (cmd_power_on),
    .GLOBAL_OFF_IN    (cmd_power_off),
    .PORT_SET_IN      (PORT_POWER_SET_IN),
    .PORT_CLR_IN      (PORT_POWER_CLR_IN),
    .POWER_OUT        (PORT_POWER_OUT)
  );

  // Suspend and resume tracking
  rhs_wakeup u_wake (
    .REF_CLK_IN        (REF_CLK_IN),
    .RESETN_IN         (RESETN_IN),
    .SUSPEND_REQ_IN    (SUSPEND_REQ_IN),
    .RESUME_DONE_IN    (RESUME_DONE_IN),
    .WAKEUP_ENABLE_IN  (remote_wakeup_enable_q),
    .CONNECT_CHANGE_IN (CONNECT_CHANGE_IN),
    .RESUME_EVENT_OUT  (resume_pulse),
    .STATE_OUT         (USB_STATE_OUT)
  );

  assign RESUME_DETECTED_OUT = resume_pulse;

  // Read mux; bits 31, 16 and 0 read zero, status low, changes high
  always_comb begin
    rdata_d = rhs_pkg::RESET_ZERO;
    resp_d  = 2'h0;
    if (hit_status) begin
      rdata_d[rhs_pkg::BIT_OVERCURRENT] =
        global_overcurrent_indicator;
      rdata_d[rhs_pkg::BIT_WAKEUP_ENABLE] = remote_wakeup_enable_q;
      rdata_d[rhs_pkg::BIT_OVERCURRENT_CHANGE] =
        overcurrent_change_flag_q;
      rdata_d[rhs_pkg::BIT_POWER_ON] = 1'b0;
      rdata_d[rhs_pkg::BIT_LOCAL_POWER_OFF] = 1'b0;
    end else if (hit_irq_stat) begin
      rdata_d[rhs_pkg::IRQ_WIDTH-1:0] = irq_stat_q;
    end else if (hit_irq_mask) begin
      rdata_d[rhs_pkg::IRQ_WIDTH-1:0] = irq_mask_q;
    end else if (hit_ctrl) begin
      rdata_d[1:0] = ctrl_q;
    end else if (!mapped) begin
      resp_d = 2'h2; // Unmapped: slave error, data zero
    end
  end

  // Read data held in flops, valid at the edge where waitrequest is low
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_READDATA_OUT <= rhs_pkg::RESET_ZERO;
      AVS_RESPONSE_OUT <= 2'h0;
    end else if (AVS_READ_IN || AVS_WRITE_IN) begin
      AVS_READDATA_OUT <= rdata_d;
      AVS_RESPONSE_OUT <= resp_d;
    end
  end

endmodule

/* File: tb/rhs_props.sv */
// Concurrent checks on the root hub status block ports
`timescale 1ns/1ps
module rhs_props (
  input wire logic        REF_CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic [7:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic [1:0]  AVS_RESPONSE_OUT,
  input wire logic        CONNECT_CHANGE_IN,
  input wire logic        SUSPEND_REQ_IN,
  input wire logic        RESUME_DETECTED_OUT,
  input wire logic [2:0]  USB_STATE_OUT
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // Bus answers one cycle after the request is seen
  wait_once_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) &&
    AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest held longer than one cycle");
  alias_ok_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
    AVS_ADDRESS_IN == 8'h94 |-> AVS_RESPONSE_OUT == 2'h0)
    else $error("write code address not decoded");
  unmapped_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
    AVS_ADDRESS_IN == 8'h40 |-> AVS_RESPONSE_OUT == 2'h2 &&
    AVS_READDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not refused");
  // Local power and command-only bits never show on a read
  read_zero_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
    AVS_ADDRESS_IN[6:0] == 7'h14 |-> AVS_READDATA_OUT[16] == 1'b0 &&
    AVS_READDATA_OUT[0] == 1'b0 && AVS_READDATA_OUT[31] == 1'b0)
    else $error("status read shows a write-only bit");
  data_hold_a: assert property (!(AVS_READ_IN || AVS_WRITE_IN)
    |=> $stable(AVS_READDATA_OUT))
    else $error("read data moved while idle");
  // Controller state tracking
  state_hot_a: assert property ($onehot(USB_STATE_OUT))
    else $error("controller state not one-hot");
  suspend_go_a: assert property (USB_STATE_OUT == rhs_pkg::ST_OPERATIONAL
    && SUSPEND_REQ_IN |=> USB_STATE_OUT == rhs_pkg::ST_SUSPEND)
    else $error("suspend request ignored");
  resume_move_a: assert property (RESUME_DETECTED_OUT |->
    USB_STATE_OUT == rhs_pkg::ST_RESUME &&
    $past(USB_STATE_OUT) == rhs_pkg::ST_SUSPEND)
    else $error("resume pulse without suspend to resume step");
  resume_cause_a: assert property ($rose(USB_STATE_OUT[2]) |->
    RESUME_DETECTED_OUT && $past(CONNECT_CHANGE_IN))
    else $error("resume entered without connect change");
endmodule

bind rhs_top rhs_props chk_u (
  .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .AVS_RESPONSE_OUT(AVS_RESPONSE_OUT),
  .CONNECT_CHANGE_IN(CONNECT_CHANGE_IN), .SUSPEND_REQ_IN(SUSPEND_REQ_IN),
  .RESUME_DETECTED_OUT(RESUME_DETECTED_OUT), .USB_STATE_OUT(USB_STATE_OUT));

/* File: tb/tb_top.sv */
// Self-checking bench for the root hub status block
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0]  resp;
  logic        wait_o, res_det, irq, oc = 1'b0, conn = 1'b0;
  logic        susp = 1'b0, rdone = 1'b0;
  logic [2:1]  msk = 2'h0, pset = 2'h0, pclr = 2'h0, power;
  logic [2:0]  state;
  // Reference model state
  logic        wake = 0, occ = 0, ocv = 0, ppm = 0, ocm = 0;
  logic [2:1]  pwr = 2'h0;
  logic [31:0] r, q;
  int          err_count = 0, compares = 0, seed = 32'h0000_f917;

  rhs_top #(.NUM_PORTS(2)) dut_u (
    .REF_CLK_IN(clk), .RESETN_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wait_o), .AVS_RESPONSE_OUT(resp),
    .OVERCURRENT_IN(oc), .PORT_POWER_MASK_IN(msk),
    .PORT_POWER_SET_IN(pset), .PORT_POWER_CLR_IN(pclr),
    .CONNECT_CHANGE_IN(conn), .SUSPEND_REQ_IN(susp),
    .RESUME_DONE_IN(rdone), .PORT_POWER_OUT(power),
    .RESUME_DETECTED_OUT(res_det), .USB_STATE_OUT(state), .IRQ_OUT(irq));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One bus access; request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    // Waitrequest and read data are taken as they stood at the edge
    @(posedge clk);
    while (wait_o !== 1'b0) @(posedge clk);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] stat();
    return {14'h0, occ, 1'b0, wake, 13'h0, ocv & ~ocm, 1'b0};
  endfunction

  // Read status through either code and compare with the model
  task automatic rdst(input logic [7:0] a);
    acc(1'b0, a, 32'h0000_0000);
    chk("status", q, stat());
    chk("power", {30'h0, power}, {30'h0, pwr});
  endtask

  // Status write, model update, then readback; wake clear wins over set
  task automatic wst(input logic [31:0] d);
    acc(1'b1, 8'h94, d);
    if (d[31]) wake = 1'b0;
    else if (d[15]) wake = 1'b1;
    if (d[17]) occ = 1'b0;
    for (int p = 1; p <= 2; p++)
      if (!ppm || !msk[p]) begin
        if (d[16]) pwr[p] = 1'b1;
        else if (d[0]) pwr[p] = 1'b0;
      end
    rdst(8'h14);
  endtask

  task automatic wctl(input logic [1:0] m);
    acc(1'b1, 8'h22, {30'h0, m});
    // Switching the reporting mode moves the global indicator too
    if (ocv && (m[1] != ocm)) occ = 1'b1;
    ppm = m[0];
    ocm = m[1];
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdst(8'h14);
    acc(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", {resp, q[29:0]}, 32'h8000_0000);
    wst(32'h0000_8000);
    rdst(8'h94);
    wst(32'h0000_0000);
    wst(32'h8000_8000);
    // Overcurrent event with its interrupt unmasked
    acc(1'b1, 8'h21, 32'h0000_0003);
    oc <= 1'b1;
    repeat (3) @(posedge clk);
    ocv = 1'b1;
    occ = 1'b1;
    rdst(8'h14);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wst(32'h0000_0000);
    wst(32'h0002_0000);
    acc(1'b1, 8'h20, 32'h0000_0003);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    wctl(2'h2);
    rdst(8'h14);
    wctl(2'h0);
    oc <= 1'b0;
    repeat (3) @(posedge clk);
    ocv = 1'b0;
    occ = 1'b1;
    wst(32'h0002_0001);
    wst(32'h0001_0000);
    wst(32'h0001_0001);
    // Random mode, mask, per-port pulses and status commands
    repeat (12) begin
      r = $random(seed);
      msk <= r[2:1];
      wctl({1'b0, r[3]});
      if (ppm) begin
        pset <= r[5:4];
        pclr <= r[7:6];
        @(posedge clk);
        pset <= 2'h0;
        pclr <= 2'h0;
        @(posedge clk);
        pwr = (pwr & ~r[7:6]) | r[5:4];
      end
      wst(r & 32'h8003_8001);
    end
    // Remote wake-up: connect change in suspend resumes when enabled
    wst(32'h0000_8000);
    acc(1'b1, 8'h20, 32'h0000_0003);
    for (int k = 0; k < 2; k++) begin
      susp <= 1'b1;
      @(posedge clk);
      susp <= 1'b0;
      conn <= 1'b1;
      @(posedge clk);
      conn <= 1'b0;
      @(negedge clk);
      chk("resume pulse", {31'h0, res_det}, {31'h0, !k});
      chk("state", {29'h0, state}, k ? 32'h0000_0002 : 32'h0000_0004);
      @(negedge clk);
      chk("irq", {31'h0, irq}, {31'h0, !k});
      @(posedge clk);
      acc(1'b1, 8'h21, 32'h0000_0000);
      chk("irq masked", {31'h0, irq}, 32'h0000_0000);
      acc(1'b1, 8'h20, 32'h0000_0003);
      acc(1'b1, 8'h21, 32'h0000_0003);
      rdone <= 1'b1;
      @(posedge clk);
      rdone <= 1'b0;
      wst(32'h8000_0000);
    end
    summarize();
  end
endmodule
